// >>> hdl/mic_flag_cell.sv
// Sticky interrupt flags set by a rising source edge or by software
`timescale 1ns/100ps
module mic_flag_cell
  import mic_pkg::*;
#(
  parameter int WIDTH = 7
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] src,
  input  wire logic [WIDTH-1:0] sw_wr,
  input  wire logic [WIDTH-1:0] sw_data,
  input  wire logic [WIDTH-1:0] hw_clr,
  output logic      [WIDTH-1:0] flag
);
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] flag_r;
  wire  [WIDTH-1:0] rise;
  wire  [WIDTH-1:0] kept;
  wire  [WIDTH-1:0] flag_nxt;

  // Edge set wins over any clear in the same cycle
  assign rise     = src & ~prev_r;
  assign kept     = flag_r & ~hw_clr;
  assign flag_nxt = ((kept & ~sw_wr) | (sw_data & sw_wr)) | rise;
  assign flag     = flag_r;

  // Source held high through reset does not count as an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_r <= '1;
      flag_r <= '0;
    end else begin
      prev_r <= src;
      flag_r <= flag_nxt;
    end
  end
endmodule

// >>> hdl/mic_irq_ctrl.sv
// Interrupt controller: flags, masking, two-level arbitration, nesting, power-down
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "mic_defs.svh"

// Contract
// - Extended enable bits 0..4 gate ADC, SPI, radio one, radio two, wakeup.
// - Extended enable and priority bits 7..5 always read as one.
// - Extended priority bits 0..4 set those sources high when one.
// - Taken interrupt redirects CPU to its routine; return resumes next instruction.
// - Each source has a fixed vector address, 0x03 through 0x63.
// - Low routine yields only to high request; high routine never nested.
// - Request waits one extra instruction after return or irq-register write.
// - Global enable at base enable bit 7 masks everything when zero.
// - Peripheral flags in ext flag bits 7..4; wakeup flag ext control bit 3.
// - Any high-level request beats every low-level request.
// - Same level ties resolved by natural order, lower number wins.
// - Timers and serial port request only through their own flag bits.
// - External pins sampled once per instruction cycle at end of phase four.
// - Pins active low; level mode flags low sample, edge mode high-then-low.
// - Level requests not latched; source holds pin until serviced.
// - Fastest response is five instruction cycles, detect plus long call.
// - Worst response is thirteen instruction cycles, fifty-two clocks.
// - Writing 0x2 or 0x3 to clock control starts power-down shutdown.
// - Only external pin, wakeup event or watchdog reset wake from power-down.
// - Restart takes 3 to 4, shutdown 2 to 3 oscillator cycles.
// - Peripheral flags set on rising edge; software writing one also requests.
module mic_irq_ctrl
  import mic_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite register port
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Interrupt sources
  input  wire logic              ext_irq0_pin,
  input  wire logic              ext_irq1_pin,
  input  wire logic              timer0_ovf,
  input  wire logic              timer1_ovf,
  input  wire logic              timer2_flag,
  input  wire logic              serial_flag,
  input  wire logic              adc_eoc,
  input  wire logic              spi_ready,
  input  wire logic              radio_ready_one,
  input  wire logic              radio_ready_two,
  input  wire logic              wakeup_event,
  input  wire logic              watchdog_reset,
  input  wire logic              low_power_oscillator,
  // CPU core handshake
  input  wire logic              cycle_c4_end,
  input  wire logic              instr_done,
  input  wire logic              instr_is_irq_return_instr,
  input  wire logic              irq_ack,
  output logic                   irq_req,
  output logic [7:0]             irq_vector,
  output logic                   irq_high,
  output logic                   cpu_hold,
  output logic                   clk_stop,
  output logic                   regulator_off
);

  // --------------------------------------------------
  // Register state
  // --------------------------------------------------
  logic [7:0] base_en_r;
  logic [5:0] base_prio_r;
  logic [4:0] ext_en_r;
  logic [4:0] ext_prio_r;
  logic [7:0] clk_ctrl_r;
  logic       ext0_edge_r;
  logic       ext1_edge_r;
  logic       run0_r;
  logic       run1_r;
  logic       samp0_r;
  logic       samp1_r;
  logic       eflag0_r;
  logic       eflag1_r;
  logic       regwr_seen_r;
  logic       act_hi_r;
  logic       act_lo_r;
  logic       irq_req_r;
  logic [7:0] irq_vec_r;
  logic       irq_high_r;
  mic_src_idx_type irq_idx_r;
  mic_pwr_state_type pwr_r;
  logic [2:0] tick_cnt_r;
  logic       lp_prev_r;
  logic       cpu_hold_r;
  logic       clk_stop_r;
  logic       reg_off_r;

  // --------------------------------------------------
  // AXI4-Lite slave
  // --------------------------------------------------
  logic              awready_r;
  logic              wready_r;
  logic              aw_full_r;
  logic              w_full_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0]        w_data_r;
  logic              w_strb_r;
  logic              bvalid_r;
  logic [1:0]        bresp_r;
  logic              arready_r;
  logic              rvalid_r;
  logic [31:0]       rdata_r;
  logic [1:0]        rresp_r;

  wire aw_take  = awvalid & awready_r;
  wire w_take   = wvalid & wready_r;
  wire wr_fire  = aw_full_r & w_full_r & ~bvalid_r;
  wire rd_take  = arvalid & arready_r;
  wire aw_full_nxt = (aw_full_r | aw_take) & ~wr_fire;
  wire w_full_nxt  = (w_full_r | w_take) & ~wr_fire;

  // Write decode on the held address, low byte lane only
  wire [7:0] wr_idx = aw_addr_r[9:2];
  wire       wr_en  = wr_fire & w_strb_r;
  wire wr_tctl  = wr_en & (wr_idx == `MIC_IDX_TIMER_CTRL);
  wire wr_eflag = wr_en & (wr_idx == `MIC_IDX_EXT_FLAG);
  wire wr_ben   = wr_en & (wr_idx == `MIC_IDX_BASE_EN);
  wire wr_clk   = wr_en & (wr_idx == `MIC_IDX_CLK_CTRL);
  wire wr_bprio = wr_en & (wr_idx == `MIC_IDX_BASE_PRIO);
  wire wr_ectrl = wr_en & (wr_idx == `MIC_IDX_EXT_CTRL);
  wire wr_een   = wr_en & (wr_idx == `MIC_IDX_EXT_EN);
  wire wr_eprio = wr_en & (wr_idx == `MIC_IDX_EXT_PRIO);
  wire wr_hit   = (wr_idx == `MIC_IDX_TIMER_CTRL) | (wr_idx == `MIC_IDX_EXT_FLAG)
                | (wr_idx == `MIC_IDX_BASE_EN) | (wr_idx == `MIC_IDX_CLK_CTRL)
                | (wr_idx == `MIC_IDX_BASE_PRIO) | (wr_idx == `MIC_IDX_EXT_CTRL)
                | (wr_idx == `MIC_IDX_EXT_EN) | (wr_idx == `MIC_IDX_EXT_PRIO);
  wire wr_irqreg = wr_ben | wr_bprio | wr_een | wr_eprio;

  // Write channel handshakes and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 8'h00;
      w_strb_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= `MIC_RESP_OKAY;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      awready_r <= ~aw_full_nxt;
      wready_r  <= ~w_full_nxt;
      if (aw_take) begin
        aw_addr_r <= awaddr;
      end
      if (w_take) begin
        w_data_r <= wdata[7:0];
        w_strb_r <= wstrb[0];
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------
  // Flags and read view
  // --------------------------------------------------
  logic [6:0] flags;
  wire  [7:0] wd = w_data_r;

  // External flag as seen by software and arbiter
  wire ext0_pend = ext0_edge_r ? eflag0_r : ~samp0_r;
  wire ext1_pend = ext1_edge_r ? eflag1_r : ~samp1_r;

  // reserved high bits read as one
  wire [7:0] rv_een   = {3'b000, ext_en_r} | `MIC_EXT_RSV_ONES;
  wire [7:0] rv_eprio = {3'b000, ext_prio_r} | `MIC_EXT_RSV_ONES;
  // peripheral flags in the upper nibble, wakeup at bit three
  wire [7:0] rv_eflag = {flags[5:2], 4'h0} | `MIC_EFLAG_ONES;
  wire [7:0] rv_ectrl = {4'h0, flags[6], 3'b000} | `MIC_ECTRL_ONES;
  wire [7:0] rv_bprio = {2'b00, base_prio_r} | `MIC_BPRIO_ONES;
  wire [7:0] rv_tctl  = {flags[1], run1_r, flags[0], run0_r,
                         ext1_pend, ext1_edge_r, ext0_pend, ext0_edge_r};

  // Read decode
  wire [7:0] rd_idx = araddr[9:2];
  wire [8:0] rd_sel =
      (rd_idx == `MIC_IDX_TIMER_CTRL) ? {1'b1, rv_tctl}   :
      (rd_idx == `MIC_IDX_EXT_FLAG)   ? {1'b1, rv_eflag}  :
      (rd_idx == `MIC_IDX_BASE_EN)    ? {1'b1, base_en_r} :
      (rd_idx == `MIC_IDX_CLK_CTRL)   ? {1'b1, clk_ctrl_r} :
      (rd_idx == `MIC_IDX_BASE_PRIO)  ? {1'b1, rv_bprio}  :
      (rd_idx == `MIC_IDX_EXT_CTRL)   ? {1'b1, rv_ectrl}  :
      (rd_idx == `MIC_IDX_EXT_EN)     ? {1'b1, rv_een}    :
      (rd_idx == `MIC_IDX_EXT_PRIO)   ? {1'b1, rv_eprio}  : 9'h000;

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `MIC_RESP_OKAY;
    end else if (rd_take) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= {24'h00_0000, rd_sel[7:0]};
      rresp_r   <= rd_sel[8] ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
    end else if (rvalid_r & rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // --------------------------------------------------
  // Sticky flags: timers, peripherals, wakeup
  // --------------------------------------------------
  wire ack_tf0 = irq_ack & irq_req_r & (irq_idx_r == `MIC_SRC_TF0);
  wire ack_tf1 = irq_ack & irq_req_r & (irq_idx_r == `MIC_SRC_TF1);

  // rising edge or software one sets, software zero clears
  // timer overflow only sets its own flag
  mic_flag_cell #(
    .WIDTH (`MIC_NUM_FLAG)
  ) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .src     ({wakeup_event, radio_ready_two, radio_ready_one, spi_ready,
               adc_eoc, timer1_ovf, timer0_ovf}),
    .sw_wr   ({wr_ectrl, {4{wr_eflag}}, wr_tctl, wr_tctl}),
    .sw_data ({wd[`MIC_WAKE_FLAG_BIT], wd[7:4], wd[`MIC_TF1_BIT], wd[`MIC_TF0_BIT]}),
    .hw_clr  ({5'b0_0000, ack_tf1, ack_tf0}),
    .flag    (flags)
  );

  // --------------------------------------------------
  // External pins, sampled once per instruction cycle
  // --------------------------------------------------
  wire fall0 = cycle_c4_end & samp0_r & ~ext_irq0_pin;
  wire fall1 = cycle_c4_end & samp1_r & ~ext_irq1_pin;
  wire ack_e0 = irq_ack & irq_req_r & (irq_idx_r == `MIC_SRC_EXT0);
  wire ack_e1 = irq_ack & irq_req_r & (irq_idx_r == `MIC_SRC_EXT1);

  // sample only at end of phase four
  // edge flag on high-then-low, set wins over clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      samp0_r  <= 1'b1;
      samp1_r  <= 1'b1;
      eflag0_r <= 1'b0;
      eflag1_r <= 1'b0;
    end else begin
      if (cycle_c4_end) begin
        samp0_r <= ext_irq0_pin;
        samp1_r <= ext_irq1_pin;
      end
      eflag0_r <= (ext0_edge_r & fall0) |
                  (wr_tctl ? wd[`MIC_EXT0_FLAG_BIT] : (eflag0_r & ~ack_e0));
      eflag1_r <= (ext1_edge_r & fall1) |
                  (wr_tctl ? wd[`MIC_EXT1_FLAG_BIT] : (eflag1_r & ~ack_e1));
    end
  end

  // Control registers written by software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_en_r   <= 8'h00;
      base_prio_r <= 6'h00;
      ext_en_r    <= 5'h00;
      ext_prio_r  <= 5'h00;
      clk_ctrl_r  <= 8'h00;
      ext0_edge_r <= 1'b0;
      ext1_edge_r <= 1'b0;
      run0_r      <= 1'b0;
      run1_r      <= 1'b0;
    end else begin
      if (wr_ben)   base_en_r   <= wd & `MIC_BASE_EN_MASK;
      if (wr_bprio) base_prio_r <= wd[5:0];
      if (wr_een)   ext_en_r    <= wd[4:0];
      if (wr_eprio) ext_prio_r  <= wd[4:0];
      if (wr_clk)   clk_ctrl_r  <= wd;
      if (wr_tctl) begin
        ext0_edge_r <= wd[`MIC_EXT0_EDGE_BIT];
        ext1_edge_r <= wd[`MIC_EXT1_EDGE_BIT];
        run0_r      <= wd[`MIC_RUN0_BIT];
        run1_r      <= wd[`MIC_RUN1_BIT];
      end
    end
  end

  // --------------------------------------------------
  // Arbitration in natural order, index 0 first
  // --------------------------------------------------
  function automatic mic_src_idx_type mic_first(input logic [`MIC_NUM_SRC-1:0] v);
    mic_src_idx_type idx;
    idx = '0;
    for (int i = `MIC_NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) idx = 4'(i);
    end
    return idx;
  endfunction

  // fixed vector per source, gap after timer 2
  function automatic logic [7:0] mic_vec(input mic_src_idx_type idx);
    mic_src_idx_type slot;
    slot = (idx < `MIC_VEC_GAP_IDX) ? idx : idx + `MIC_VEC_SKIP;
    return `MIC_VEC_BASE + `MIC_VEC_STEP * {4'h0, slot};
  endfunction

  wire [`MIC_NUM_SRC-1:0] src_pend = {flags[6], flags[5], flags[4], flags[3],
      flags[2], timer2_flag, serial_flag, flags[1], ext1_pend, flags[0], ext0_pend};
  wire [`MIC_NUM_SRC-1:0] src_en   = {ext_en_r, base_en_r[5:0]};
  wire [`MIC_NUM_SRC-1:0] src_prio = {ext_prio_r, base_prio_r};

  // global enable gates every source enable
  wire [`MIC_NUM_SRC-1:0] live = src_pend & src_en &
                                 {`MIC_NUM_SRC{base_en_r[`MIC_GLOBAL_EN_BIT]}};
  wire [`MIC_NUM_SRC-1:0] live_hi = live & src_prio;
  wire [`MIC_NUM_SRC-1:0] live_lo = live & ~src_prio;

  // high blocked by active high; low by any active level
  wire use_hi = (|live_hi) & ~act_hi_r;
  wire use_lo = (|live_lo) & ~act_hi_r & ~act_lo_r;
  // high level wins; natural order within a level
  wire             win_valid = use_hi | use_lo;
  mic_src_idx_type win_idx;
  assign win_idx = use_hi ? mic_first(live_hi) : mic_first(live_lo);

  // boundary after a return or irq register write is skipped
  wire boundary_ok = instr_done & ~instr_is_irq_return_instr & ~regwr_seen_r &
                     ~wr_irqreg & (pwr_r == MIC_RUN);
  wire irq_return_instr_done   = instr_done & instr_is_irq_return_instr;
  wire take        = irq_ack & irq_req_r;

  // Remember irq register writes until the next instruction ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regwr_seen_r <= 1'b0;
    end else begin
      regwr_seen_r <= wr_irqreg | (regwr_seen_r & ~instr_done);
    end
  end

  // one clock from boundary to request
  // strobe and vector to the core at an instruction boundary
  // request withdrawn when no live source is left before the call; otherwise its vector is kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_req_r  <= 1'b0;
      irq_vec_r  <= 8'h00;
      irq_high_r <= 1'b0;
      irq_idx_r  <= '0;
    end else if (take | (irq_req_r & ~win_valid)) begin
      irq_req_r <= 1'b0;
    end else if (~irq_req_r & boundary_ok & win_valid) begin
      irq_req_r  <= 1'b1;
      irq_vec_r  <= mic_vec(win_idx);
      irq_high_r <= use_hi;
      irq_idx_r  <= win_idx;
    end
  end

  // level recorded at the call, released by the matching return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_hi_r <= 1'b0;
      act_lo_r <= 1'b0;
    end else if (take) begin
      act_hi_r <= act_hi_r | irq_high_r;
      act_lo_r <= act_lo_r | ~irq_high_r;
    end else if (irq_return_instr_done) begin
      act_hi_r <= 1'b0;
      act_lo_r <= act_lo_r & act_hi_r;
    end
  end

  // --------------------------------------------------
  // Power-down sequencing on oscillator ticks
  // --------------------------------------------------
  wire lp_tick  = low_power_oscillator & ~lp_prev_r;
  wire pd_write = wr_clk & ((wd == `MIC_PD_CODE_A) | (wd == `MIC_PD_CODE_B));
  // only pins, wakeup event or watchdog may wake
  wire wake_src = ~ext_irq0_pin | ~ext_irq1_pin | wakeup_event | watchdog_reset;

  // shutdown on code write; counted in oscillator ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_r      <= MIC_RUN;
      tick_cnt_r <= 3'h0;
      lp_prev_r  <= 1'b0;
      cpu_hold_r <= 1'b0;
      clk_stop_r <= 1'b0;
      reg_off_r  <= 1'b0;
    end else begin
      lp_prev_r <= low_power_oscillator;
      case (pwr_r)
        MIC_RUN: begin
          if (pd_write) begin
            pwr_r      <= MIC_SHUT;
            tick_cnt_r <= 3'h0;
            cpu_hold_r <= 1'b1;
          end
        end
        MIC_SHUT: begin
          if (lp_tick) begin
            tick_cnt_r <= tick_cnt_r + 3'h1;
          end
          if (lp_tick & (tick_cnt_r + 3'h1 == `MIC_SHUTDOWN_TICKS)) begin
            pwr_r      <= MIC_DOWN;
            clk_stop_r <= 1'b1;
            reg_off_r  <= 1'b1;
          end
        end
        MIC_DOWN: begin
          if (wake_src) begin
            pwr_r      <= MIC_RESTART;
            tick_cnt_r <= 3'h0;
            reg_off_r  <= 1'b0;
          end
        end
        MIC_RESTART: begin
          if (lp_tick) begin
            tick_cnt_r <= tick_cnt_r + 3'h1;
          end
          if (lp_tick & (tick_cnt_r + 3'h1 == `MIC_RESTART_TICKS)) begin
            pwr_r      <= MIC_RUN;
            clk_stop_r <= 1'b0;
            cpu_hold_r <= 1'b0;
          end
        end
        default: begin
          pwr_r <= MIC_RUN;
        end
      endcase
    end
  end

  // --------------------------------------------------
  // Outputs, all from flip-flops
  // --------------------------------------------------
  assign awready       = awready_r;
  assign wready        = wready_r;
  assign bvalid        = bvalid_r;
  assign bresp         = bresp_r;
  assign arready       = arready_r;
  assign rvalid        = rvalid_r;
  assign rdata         = rdata_r;
  assign rresp         = rresp_r;
  assign irq_req       = irq_req_r;
  assign irq_vector    = irq_vec_r;
  assign irq_high      = irq_high_r;
  assign cpu_hold      = cpu_hold_r;
  assign clk_stop      = clk_stop_r;
  assign regulator_off = reg_off_r;

endmodule

// >>> include/mic_defs.svh
// Register indices, field positions and counts of the interrupt controller
`ifndef MIC_DEFS_SVH
`define MIC_DEFS_SVH

// --------------------------------------------------
// Register indices (byte address is four times these)
// --------------------------------------------------
`define MIC_IDX_TIMER_CTRL 8'h88
`define MIC_IDX_EXT_FLAG   8'h91
`define MIC_IDX_BASE_EN    8'ha8
`define MIC_IDX_CLK_CTRL   8'hb6
`define MIC_IDX_BASE_PRIO  8'hb8
`define MIC_IDX_EXT_CTRL   8'hd8
`define MIC_IDX_EXT_EN     8'he8
`define MIC_IDX_EXT_PRIO   8'hf8

// --------------------------------------------------
// Fields and read-as-one masks
// --------------------------------------------------
`define MIC_EXT_RSV_ONES   8'he0
`define MIC_BPRIO_ONES     8'h80
`define MIC_EFLAG_ONES     8'h08
`define MIC_ECTRL_ONES     8'h40
`define MIC_BASE_EN_MASK   8'hbf
`define MIC_GLOBAL_EN_BIT  7
`define MIC_EXT0_EDGE_BIT  0
`define MIC_EXT0_FLAG_BIT  1
`define MIC_EXT1_EDGE_BIT  2
`define MIC_EXT1_FLAG_BIT  3
`define MIC_RUN0_BIT       4
`define MIC_TF0_BIT        5
`define MIC_RUN1_BIT       6
`define MIC_TF1_BIT        7
`define MIC_WAKE_FLAG_BIT  3

// --------------------------------------------------
// Sources, vectors, power and bus answers
// --------------------------------------------------
`define MIC_NUM_SRC        11
`define MIC_NUM_FLAG       7
`define MIC_SRC_EXT0       4'h0
`define MIC_SRC_TF0        4'h1
`define MIC_SRC_EXT1       4'h2
`define MIC_SRC_TF1        4'h3
`define MIC_VEC_BASE       8'h03
`define MIC_VEC_STEP       8'h08
`define MIC_VEC_GAP_IDX    4'h6
`define MIC_VEC_SKIP       4'h2
`define MIC_PD_CODE_A      8'h02
`define MIC_PD_CODE_B      8'h03
`define MIC_SHUTDOWN_TICKS 3'h2
`define MIC_RESTART_TICKS  3'h3
`define MIC_RESP_OKAY      2'b00
`define MIC_RESP_SLVERR    2'b10

`endif

// >>> include/mic_pkg.sv
// Types shared by the interrupt controller files
package mic_pkg;
  typedef enum logic [1:0] {MIC_RUN, MIC_SHUT, MIC_DOWN, MIC_RESTART} mic_pwr_state_type;
  typedef logic [3:0] mic_src_idx_type;
endpackage

// >>> tb/mic_core_model.sv
// Core model: four-clock instruction cycles, call start and return
`timescale 1ns/100ps
module mic_core_model (
  input wire logic aclk, aresetn, irq_req, ack_en, irq_return_instr_go,
  output logic     cycle_c4_end, instr_done, instr_is_irq_return_instr, irq_ack
);
  logic [1:0] phase_r;
  // phase four ends each cycle; call starts on a pending request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {phase_r, cycle_c4_end, instr_done, instr_is_irq_return_instr, irq_ack} <= '0;
    end else begin
      phase_r       <= phase_r + 2'h1;
      cycle_c4_end  <= phase_r == 2'h2;
      instr_done    <= phase_r == 2'h2;
      instr_is_irq_return_instr <= irq_return_instr_go && phase_r == 2'h2;
      irq_ack       <= ack_en && irq_req && phase_r == 2'h0;
    end
  end
endmodule

// >>> tb/mic_irq_ctrl_props.sv
// Port assertions for the interrupt controller
`timescale 1ns/100ps
module mic_irq_ctrl_props
  import mic_pkg::*;
(
  input wire logic        aclk, aresetn, arvalid, arready, rvalid, irq_ack,
  input wire logic        instr_done, instr_is_irq_return_instr, irq_req, irq_high,
  input wire logic        cpu_hold, clk_stop, regulator_off,
  input wire logic [9:0]  araddr,
  input wire logic [7:0]  irq_vector,
  input wire logic [31:0] rdata
);
  logic [9:0] ra_r;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Address of the read being answered
  always_ff @(posedge aclk) if (arvalid && arready) ra_r <= araddr;
  a_req_boundary: assert property (
    $rose(irq_req) |-> $past(instr_done) && !$past(instr_is_irq_return_instr)) else $error("raise off bound");
  a_ack_drops_req: assert property (
    irq_ack && irq_req |=> !irq_req) else $error("request kept after ack");
  a_vector_steady: assert property (
    irq_req ##1 irq_req |-> $stable(irq_vector)) else $error("vector moved");
  a_vector_table: assert property (
    irq_req |-> irq_vector[2:0] == 3'h3 && irq_vector <= 8'h63 && irq_vector[7:4] != 4'h3)
    else $error("vector off table");
  a_hold_no_raise: assert property (
    $rose(irq_req) |-> !$past(cpu_hold)) else $error("raise while down");
  a_stop_under_hold: assert property (
    clk_stop |-> cpu_hold) else $error("clock stopped but core free");
  a_regulator_clock: assert property (
    regulator_off |-> clk_stop) else $error("regulator off with clock on");
  a_reserved_ones: assert property (
    rvalid && (ra_r == 10'h3a0 || ra_r == 10'h3e0) |-> rdata[7:5] == 3'h7)
    else $error("reserved bits not one");
  c_high_req: cover property (irq_req && irq_high);
  c_ack: cover property (irq_ack);
  c_down: cover property (regulator_off);
endmodule

// >>> tb/mic_irq_ctrl_tb.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/100ps
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end
`define WT(c) begin for (k = 0; k < 3000 && !(c); k++) @(posedge aclk); \
  if (!(c)) begin errors++; end_of_test(); end end
module mic_irq_ctrl_tb;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, ext_irq0_pin, ext_irq1_pin, timer0_ovf, timer1_ovf, timer2_flag;
  logic serial_flag, adc_eoc, spi_ready, radio_ready_one, radio_ready_two, wakeup_event;
  logic watchdog_reset, low_power_oscillator, cycle_c4_end, instr_done, instr_is_irq_return_instr;
  logic irq_ack, irq_req, irq_high, cpu_hold, clk_stop, regulator_off, ack_en, irq_return_instr_go;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q, st = 32'h5, st2 = 32'h5;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic [7:0]  irq_vector, e, p;
  logic [4:0]  lp_r = 5'h0;
  int          errors = 0, tests_run = 0, k;
  mic_irq_ctrl i_dut (.*);
  mic_core_model i_core (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // Expected {level, vector}: high level first, then lowest natural number
  function automatic logic [8:0] win(input logic [7:0] en, pr);
    logic h;
    logic [7:0] v;
    h = |(en & pr & 8'h1f);
    v = 8'h00;
    for (int i = 4; i >= 0; i--) if (en[i] && (pr[i] || !h)) v = i == 4 ? 8'h63 : 8'h43 + 8'(i * 8);
    return {h, v};
  endfunction
  task end_of_test;
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One register access; each channel released when taken
  task acc(input logic w, input logic [7:0] i, d);
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {i, 2'b0, i, 2'b0, 24'h0, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    for (k = 0; k < 100; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (arready) arvalid <= 0;
      if (bvalid || rvalid) break;
    end
    q = rdata;
    r = w ? bresp : rresp;
    {bready, rready} <= 2'b0;
    if (k == 100) begin errors++; end_of_test(); end
  endtask
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  // Masked timer sources toggle at random; slow oscillator runs free
  always @(posedge aclk) begin
    st2 <= xs(st2);
    lp_r <= lp_r + 5'h1;
    low_power_oscillator <= lp_r[4];
    {timer0_ovf, timer1_ovf, timer2_flag, serial_flag} <= st2[3:0];
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ack_en, irq_return_instr_go, watchdog_reset} = '0;
    {adc_eoc, spi_ready, radio_ready_one, radio_ready_two, wakeup_event, awaddr} = '0;
    {araddr, wdata, ext_irq0_pin, ext_irq1_pin, wstrb} = {42'h0, 6'h31};
    repeat (5) @(posedge aclk);
    aresetn <= 1;
    acc(0, 8'he8, 0); `CK("enable", 32'he0, q)
    acc(0, 8'hf8, 0); `CK("priority", 32'he0, q)
    acc(0, 8'h00, 0); `CK("unmapped", 2'b10, r)
    {adc_eoc, spi_ready, radio_ready_one, radio_ready_two, wakeup_event} <= 5'h1f;
    acc(1, 8'he8, 8'h1f);
    repeat (40) @(posedge aclk);
    `CK("global off", 1'b0, irq_req)
    acc(1, 8'ha8, 8'h80);
    for (int n = 0; n < 8; n++) begin
      st = xs(st);
      e = n == 7 ? 8'h1f : st[7:0] & 8'h1f | 8'h01;
      p = n == 7 ? 8'h00 : n == 0 ? 8'hff : st[15:8];
      acc(1, 8'he8, 0);
      acc(1, 8'hf8, p);
      acc(0, 8'hf8, 0); `CK("priority", {24'h0, p & 8'h1f | 8'he0}, q)
      acc(1, 8'he8, e);
      acc(0, 8'he8, 0); `CK("enable", {24'h0, e | 8'he0}, q)
      `WT(irq_req)
      `CK("winner", win(e, p), {irq_high, irq_vector})
    end
    ack_en <= 1;
    `WT(irq_ack)
    ack_en <= 0;
    repeat (40) @(posedge aclk);
    `CK("low nest", 1'b0, irq_req)
    acc(1, 8'hf8, 8'h02);
    `WT(irq_req)
    `CK("preempt", 9'h14b, {irq_high, irq_vector})
    ack_en <= 1;
    `WT(irq_ack)
    ack_en <= 0;
    repeat (40) @(posedge aclk);
    `CK("high nest", 1'b0, irq_req)
    irq_return_instr_go <= 1;
    repeat (4) @(posedge aclk);
    irq_return_instr_go <= 0;
    `WT(irq_req)
    `CK("after return", 9'h14b, {irq_high, irq_vector})
    ack_en <= 1;
    `WT(irq_ack)
    ack_en <= 0;
    acc(1, 8'hf8, 8'h00);
    irq_return_instr_go <= 1;
    repeat (4) @(posedge aclk);
    irq_return_instr_go <= 0;
    repeat (40) @(posedge aclk);
    `CK("low kept", 1'b0, irq_req)
    wakeup_event <= 0;
    acc(1, 8'hb6, 8'h02);
    `WT(clk_stop && regulator_off)
    `CK("hold", 1'b1, cpu_hold)
    adc_eoc <= 0;
    repeat (40) @(posedge aclk);
    adc_eoc <= 1;
    repeat (80) @(posedge aclk);
    `CK("no wake", 1'b1, regulator_off)
    ext_irq0_pin <= 0;
    `WT(!cpu_hold)
    `CK("restart", 1'b0, clk_stop)
    acc(1, 8'h88, 8'h01);
    ext_irq0_pin <= 1;
    repeat (4) @(posedge aclk);
    ext_irq0_pin <= 0;
    repeat (4) @(posedge aclk);
    acc(0, 8'h88, 0);
    `CK("edge flag", 4'h3, q[3:0])
    end_of_test();
  end
endmodule
bind mic_irq_ctrl mic_irq_ctrl_props i_chk (.*);
